/* File: rtl/seq_table_pkg.sv */
// constants and types shared by the sequence table entry decoder
package seq_table_pkg;

  // ****************************************
  // table geometry
  // ****************************************
  localparam int WORD_W        = 32;
  localparam int ENTRY_WORDS   = 6;
  localparam int TABLE_ENTRIES = 524287;
  localparam int TABLE_WORDS   = TABLE_ENTRIES * ENTRY_WORDS;
  localparam int IDX_W         = 19;
  localparam int ADDR_W        = 22;
  localparam logic [IDX_W-1:0] LAST_INDEX = 19'h7_FFFE;

  // word positions inside one entry
  localparam logic [2:0] W_CTRL     = 3'h0;
  localparam logic [2:0] W_SEQ_LOOP = 3'h1;
  localparam logic [2:0] W_SEG_LOOP = 3'h2;
  localparam logic [2:0] W_CMD      = 3'h2;
  localparam logic [2:0] W_SEG_ID   = 3'h3;
  localparam logic [2:0] W_IDLE_SMP = 3'h3;
  localparam logic [2:0] W_START    = 3'h4;
  localparam logic [2:0] W_DELAY    = 3'h4;
  localparam logic [2:0] W_END      = 3'h5;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int CTL_CMD_BIT      = 31;
  localparam int CTL_SEQ_END_BIT  = 30;
  localparam int CTL_SCEN_END_BIT = 29;
  localparam int CTL_SEQ_INIT_BIT = 28;
  localparam int CTL_MARKER_BIT   = 24;
  localparam int SEQ_ADV_LSB      = 20;
  localparam int SEG_ADV_LSB      = 16;
  localparam int ADV_W            = 4;
  localparam int AMP_INIT_BIT     = 15;
  localparam int AMP_INC_BIT      = 14;
  localparam int FRQ_INIT_BIT     = 13;
  localparam int FRQ_INC_BIT      = 12;

  localparam logic [ADV_W-1:0] ADV_AUTO = 4'h0;
  localparam logic [ADV_W-1:0] ADV_COND = 4'h1;
  localparam logic [ADV_W-1:0] ADV_REP  = 4'h2;
  localparam logic [ADV_W-1:0] ADV_SNGL = 4'h3;

  // ****************************************
  // other words
  // ****************************************
  localparam int SEG_ID_W   = 19;
  localparam int CMD_CODE_W = 16;
  localparam int ACTION_LSB = 16;
  localparam int ACTION_W   = 16;
  localparam logic [CMD_CODE_W-1:0] CMD_IDLE   = 16'h0000;
  localparam logic [CMD_CODE_W-1:0] CMD_CONFIG = 16'h0001;
  localparam logic [WORD_W-1:0]     END_TO_LAST = 32'hFFFF_FFFF;
  localparam int IQ_W        = 15;
  localparam int IDLE_I_LSB  = 0;
  localparam int IDLE_Q_LSB  = 16;
  localparam int FINE_DAC_W  = 14;
  localparam int FAST_DAC_W  = 12;

  // ****************************************
  // idle delay limits, in delay units
  // ****************************************
  localparam int DLY_W = 40;
  localparam logic [DLY_W-1:0] MIN_DLY_FAST   = 40'(10 * 64);
  localparam logic [DLY_W-1:0] MIN_DLY_FINE   = 40'(10 * 48);
  localparam logic [DLY_W-1:0] MIN_DLY_INTERP = 40'(10 * 24);
  localparam logic [DLY_W-1:0] MAX_DLY_FAST   = (40'h00_0000_0001 << 25) * 40'd64 + 40'd63;
  localparam logic [DLY_W-1:0] MAX_DLY_FINE   = (40'h00_0000_0001 << 25) * 40'd48 + 40'd47;
  localparam logic [DLY_W-1:0] MAX_DLY_INTERP = (40'h00_0000_0001 << 25) * 40'd24 + 40'd23;
  localparam logic [DLY_W-1:0] FACTOR_X3  = 40'd3;
  localparam logic [DLY_W-1:0] FACTOR_X12 = 40'd12;
  localparam logic [DLY_W-1:0] FACTOR_X24 = 40'd24;
  localparam logic [DLY_W-1:0] FACTOR_X48 = 40'd48;

  typedef enum logic [2:0] {
    direct_fast_output,
    direct_fine_output,
    interp_by_three,
    interp_by_twelve,
    interp_by_twentyfour,
    interp_by_fortyeight
  } out_mode_t;

  typedef enum logic [1:0] {kind_data, kind_idle, kind_config, kind_bad} entry_kind_t;

endpackage

/* File: rtl/entry_if.sv */
// raw entry words and their decoded fields between decoder and sequencer
`timescale 1ns/1ps
interface entry_if;
  import seq_table_pkg::*;
  logic [ENTRY_WORDS-1:0][WORD_W-1:0] words;
  entry_kind_t                        kind;
  logic                               seq_end;
  logic                               scen_end;
  logic                               seq_init;
  logic                               marker_en;
  logic [ADV_W-1:0]                   seq_adv;
  logic [ADV_W-1:0]                   seg_adv;
  logic [3:0]                         table_flags;
  logic [WORD_W-1:0]                  seq_loop;
  logic [WORD_W-1:0]                  seg_loop;
  logic [SEG_ID_W-1:0]                seg_id;
  logic [WORD_W-1:0]                  start_off;
  logic [WORD_W-1:0]                  end_off;
  logic                               end_is_last;
  logic [ACTION_W-1:0]                action_id;
  logic [WORD_W-1:0]                  idle_sample;
  logic [WORD_W-1:0]                  idle_delay;

  modport dec (input words, output kind, seq_end, scen_end, seq_init, marker_en, seq_adv, seg_adv,
               table_flags, seq_loop, seg_loop, seg_id, start_off, end_off, end_is_last, action_id,
               idle_sample, idle_delay);
  modport user (output words, input kind, seq_end, scen_end, seq_init, marker_en, seq_adv, seg_adv,
                table_flags, seq_loop, seg_loop, seg_id, start_off, end_off, end_is_last, action_id,
                idle_sample, idle_delay);
endinterface

/* File: rtl/entry_decoder.sv */
// splits one six-word table entry into its typed fields
`timescale 1ns/1ps
module entry_decoder
  import seq_table_pkg::*;
(
  entry_if.dec e
);

  logic [WORD_W-1:0] ctl;
  logic [WORD_W-1:0] cmd;

  always_comb begin
    ctl = e.words[W_CTRL];
    cmd = e.words[W_CMD];
    if (!ctl[CTL_CMD_BIT]) begin
      e.kind = kind_data;
    end else if (cmd[CMD_CODE_W-1:0] == CMD_IDLE) begin
      e.kind = kind_idle;
    end else if (cmd[CMD_CODE_W-1:0] == CMD_CONFIG) begin
      e.kind = kind_config;
    end else begin
      e.kind = kind_bad;
    end
    e.seq_end   = ctl[CTL_SEQ_END_BIT];
    e.scen_end  = ctl[CTL_SCEN_END_BIT];
    e.seq_init  = ctl[CTL_SEQ_INIT_BIT];
    // marker and segment advance have no meaning for idle entries
    e.marker_en = ctl[CTL_MARKER_BIT] && (e.kind != kind_idle);
    e.seq_adv   = ctl[SEQ_ADV_LSB +: ADV_W];
    e.seg_adv   = (e.kind == kind_idle) ? ADV_AUTO : ctl[SEG_ADV_LSB +: ADV_W];
    e.table_flags = (e.kind == kind_config) ? 4'h0 :
                    {ctl[AMP_INIT_BIT], ctl[AMP_INC_BIT], ctl[FRQ_INIT_BIT], ctl[FRQ_INC_BIT]};
    e.seq_loop    = e.words[W_SEQ_LOOP];
    e.seg_loop    = (e.kind == kind_data) ? e.words[W_SEG_LOOP] : 32'h0000_0001;
    e.seg_id      = e.words[W_SEG_ID][SEG_ID_W-1:0];
    e.start_off   = e.words[W_START];
    e.end_off     = e.words[W_END];
    e.end_is_last = (e.words[W_END] == END_TO_LAST);
    e.action_id   = cmd[ACTION_LSB +: ACTION_W];
    e.idle_sample = e.words[W_IDLE_SMP];
    e.idle_delay  = e.words[W_DELAY];
  end

endmodule

/* File: rtl/seq_table_sequencer.sv */
// sequence table store, entry fetch and playback sequencing
//
// Operation
// - entry is six words, segment id 19 bits
// - control bits select kind and sequence markers
// - sequence and segment advancement mode fields
// - amplitude and frequency table flags, not config
// - sequence loop count taken from first entry
// - segment loop count repeats data segment
// - start offset restricts segment, writer keeps granularity
// - end offset, all ones means last sample
// - command code selects idle or configuration
// - interpolated idle sample I and Q fields
// - direct idle value width follows output mode
// - idle delay units, minimum and maximum
// - table holds 524287 entries of six words
`timescale 1ns/1ps
module seq_table_sequencer
  import seq_table_pkg::*;
(
  // clock, reset, enable
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  // table access from software
  input  wire logic                wr_en,
  input  wire logic [IDX_W-1:0]    wr_index,
  input  wire logic [2:0]          wr_word,
  input  wire logic [WORD_W-1:0]   wr_data,
  input  wire logic                rd_en,
  input  wire logic [IDX_W-1:0]    rd_index,
  input  wire logic [2:0]          rd_word,
  output logic      [WORD_W-1:0]   rd_data_q,
  // run control
  input  wire logic                start,
  input  wire logic                stop,
  input  wire logic [IDX_W-1:0]    start_index,
  input  wire out_mode_t           out_mode,
  output logic                     busy_q,
  output logic                     done_q,
  output logic                     bad_entry_q,
  output logic      [IDX_W-1:0]    cur_index_q,
  // waveform memory read path
  output logic                     mem_req_q,
  output logic      [SEG_ID_W-1:0] seg_id_q,
  output logic      [WORD_W-1:0]   start_off_q,
  output logic      [WORD_W-1:0]   end_off_q,
  output logic                     end_last_q,
  input  wire logic                mem_done,
  // entry flags
  output logic                     marker_en_q,
  output logic      [ADV_W-1:0]    seq_adv_q,
  output logic      [ADV_W-1:0]    seg_adv_q,
  output logic      [3:0]          table_flags_q,
  output logic                     config_q,
  output logic      [ACTION_W-1:0] action_id_q,
  // idle sample output
  output logic                     idle_active_q,
  output logic      [IQ_W-1:0]     idle_i_q,
  output logic      [IQ_W-1:0]     idle_q_q,
  output logic      [FINE_DAC_W-1:0] idle_dac_q
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [ADDR_W-1:0] entry_addr(input logic [IDX_W-1:0] idx, input logic [2:0] w);
    entry_addr = ADDR_W'(idx * ENTRY_WORDS) + ADDR_W'(w);
  endfunction

  // converts the delay word into sample clocks, clamped to the legal range
  function automatic logic [DLY_W-1:0] delay_cycles(input logic [WORD_W-1:0] v, input out_mode_t m);
    logic [DLY_W-1:0] units;
    logic [DLY_W-1:0] lo;
    logic [DLY_W-1:0] hi;
    logic [DLY_W-1:0] f;
    units = DLY_W'(v);
    case (m)
      direct_fast_output: begin lo = MIN_DLY_FAST; hi = MAX_DLY_FAST; f = 40'd1; end
      direct_fine_output: begin lo = MIN_DLY_FINE; hi = MAX_DLY_FINE; f = 40'd1; end
      interp_by_three:    begin lo = MIN_DLY_INTERP; hi = MAX_DLY_INTERP; f = FACTOR_X3; end
      interp_by_twelve:   begin lo = MIN_DLY_INTERP; hi = MAX_DLY_INTERP; f = FACTOR_X12; end
      interp_by_twentyfour: begin lo = MIN_DLY_INTERP; hi = MAX_DLY_INTERP; f = FACTOR_X24; end
      default:            begin lo = MIN_DLY_INTERP; hi = MAX_DLY_INTERP; f = FACTOR_X48; end
    endcase
    if (units < lo) units = lo;
    if (units > hi) units = hi;
    delay_cycles = DLY_W'(units * f);
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {s_idle, s_fetch, s_decode, s_play_req, s_play_wait, s_delay, s_next} fsm_t;

  typedef struct packed {
    fsm_t                               fsm;
    logic [2:0]                         word_cnt;
    logic [ENTRY_WORDS-1:0][WORD_W-1:0] words;
    logic [IDX_W-1:0]                   idx;
    logic [IDX_W-1:0]                   seq_start;
    logic                               seq_first;
    logic [WORD_W-1:0]                  seq_count;
    logic [WORD_W-1:0]                  seq_iter;
    logic [WORD_W-1:0]                  seg_count;
    logic [WORD_W-1:0]                  seg_iter;
    logic [DLY_W-1:0]                   dly_cnt;
    logic                               cur_seq_end;
    logic                               cur_scen_end;
    logic                               busy;
    logic                               done;
    logic                               bad;
    logic                               mem_req;
    logic [SEG_ID_W-1:0]                seg_id;
    logic [WORD_W-1:0]                  start_off;
    logic [WORD_W-1:0]                  end_off;
    logic                               end_last;
    logic                               marker_en;
    logic [ADV_W-1:0]                   seq_adv;
    logic [ADV_W-1:0]                   seg_adv;
    logic [3:0]                         table_flags;
    logic                               cfg;
    logic [ACTION_W-1:0]                action_id;
    logic                               idle_active;
    logic [IQ_W-1:0]                    idle_i;
    logic [IQ_W-1:0]                    idle_q;
    logic [FINE_DAC_W-1:0]              idle_dac;
  } st_t;

  st_t st_q;
  st_t st_d;

  // ****************************************
  // table memory
  // ****************************************
  logic [WORD_W-1:0] table_mem [0:TABLE_WORDS-1];
  logic [WORD_W-1:0] fetch_word_q;

  // fetch and software read share the array but use separate read ports
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (wr_en && wr_index <= LAST_INDEX && wr_word < 3'(ENTRY_WORDS)) begin
        table_mem[entry_addr(wr_index, wr_word)] <= wr_data;
      end
      fetch_word_q <= table_mem[entry_addr(st_q.idx, st_q.word_cnt)];
      if (!rstn) begin
        rd_data_q <= 32'h0000_0000;
      end else if (rd_en && rd_index <= LAST_INDEX && rd_word < 3'(ENTRY_WORDS)) begin
        rd_data_q <= table_mem[entry_addr(rd_index, rd_word)];
      end
    end
  end

  entry_if ent ();
  assign ent.words = st_q.words;

  entry_decoder u_dec (
    .e (ent)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    st_d         = st_q;
    st_d.mem_req = 1'b0;
    st_d.cfg     = 1'b0;
    st_d.done    = 1'b0;
    case (st_q.fsm)
      s_idle: begin
        st_d.busy = 1'b0;
        if (start) begin
          st_d.idx       = start_index;
          st_d.seq_first = 1'b1;
          st_d.word_cnt  = 3'h0;
          st_d.busy      = 1'b1;
          st_d.bad       = 1'b0;
          st_d.fsm       = s_fetch;
        end
      end
      s_fetch: begin
        // read data lags the address by one cycle
        if (st_q.word_cnt != 3'h0) begin
          st_d.words[st_q.word_cnt - 3'h1] = fetch_word_q;
        end
        if (st_q.word_cnt == 3'(ENTRY_WORDS)) begin
          st_d.fsm = s_decode;
        end else begin
          st_d.word_cnt = st_q.word_cnt + 3'h1;
        end
      end
      s_decode: begin
        st_d.cur_seq_end  = ent.seq_end;
        st_d.cur_scen_end = ent.scen_end;
        // looping back onto the start entry must not restart the iteration count
        if (st_q.seq_first || (ent.seq_init && st_q.idx != st_q.seq_start)) begin
          st_d.seq_count = ent.seq_loop;
          st_d.seq_iter  = 32'h0000_0000;
          st_d.seq_start = st_q.idx;
          st_d.seq_first = 1'b0;
        end
        st_d.marker_en   = ent.marker_en;
        st_d.seq_adv     = ent.seq_adv;
        st_d.seg_adv     = ent.seg_adv;
        st_d.table_flags = ent.table_flags;
        st_d.seg_id      = ent.seg_id;
        st_d.start_off   = ent.start_off;
        st_d.end_off     = ent.end_off;
        st_d.end_last    = ent.end_is_last;
        st_d.seg_count   = ent.seg_loop;
        st_d.seg_iter    = 32'h0000_0000;
        case (ent.kind)
          kind_data: begin
            st_d.fsm = s_play_req;
          end
          kind_config: begin
            st_d.cfg       = 1'b1;
            st_d.action_id = ent.action_id;
            st_d.fsm       = s_play_req;
          end
          kind_idle: begin
            st_d.idle_active = 1'b1;
            st_d.idle_i      = ent.idle_sample[IDLE_I_LSB +: IQ_W];
            st_d.idle_q      = ent.idle_sample[IDLE_Q_LSB +: IQ_W];
            st_d.idle_dac    = (out_mode == direct_fast_output) ?
                               FINE_DAC_W'(ent.idle_sample[FAST_DAC_W-1:0]) :
                               ent.idle_sample[FINE_DAC_W-1:0];
            st_d.dly_cnt     = delay_cycles(ent.idle_delay, out_mode);
            st_d.fsm         = s_delay;
          end
          default: begin
            st_d.bad = 1'b1;
            st_d.fsm = s_next;
          end
        endcase
      end
      s_play_req: begin
        st_d.mem_req = 1'b1;
        st_d.fsm     = s_play_wait;
      end
      s_play_wait: begin
        if (mem_done) begin
          st_d.seg_iter = st_q.seg_iter + 32'h0000_0001;
          // a zero loop count plays the segment once
          if (st_q.seg_iter + 32'h0000_0001 >= st_q.seg_count) begin
            st_d.fsm = s_next;
          end else begin
            st_d.fsm = s_play_req;
          end
        end
      end
      s_delay: begin
        if (st_q.dly_cnt <= 40'h00_0000_0001) begin
          st_d.idle_active = 1'b0;
          st_d.fsm         = s_next;
        end else begin
          st_d.dly_cnt = st_q.dly_cnt - 40'h00_0000_0001;
        end
      end
      s_next: begin
        st_d.word_cnt = 3'h0;
        st_d.fsm      = s_fetch;
        if (st_q.cur_seq_end && st_q.seq_iter + 32'h0000_0001 < st_q.seq_count) begin
          st_d.seq_iter = st_q.seq_iter + 32'h0000_0001;
          st_d.idx      = st_q.seq_start;
        end else if ((st_q.cur_seq_end && st_q.cur_scen_end) || st_q.idx == LAST_INDEX) begin
          st_d.done = 1'b1;
          st_d.busy = 1'b0;
          st_d.fsm  = s_idle;
        end else begin
          st_d.seq_first = st_q.cur_seq_end;
          st_d.idx       = st_q.idx + IDX_W'(1);
        end
      end
      default: begin
        st_d.fsm = s_idle;
      end
    endcase
    if (stop) begin
      st_d.fsm         = s_idle;
      st_d.busy        = 1'b0;
      st_d.idle_active = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign busy_q        = st_q.busy;
  assign done_q        = st_q.done;
  assign bad_entry_q   = st_q.bad;
  assign cur_index_q   = st_q.idx;
  assign mem_req_q     = st_q.mem_req;
  assign seg_id_q      = st_q.seg_id;
  assign start_off_q   = st_q.start_off;
  assign end_off_q     = st_q.end_off;
  assign end_last_q    = st_q.end_last;
  assign marker_en_q   = st_q.marker_en;
  assign seq_adv_q     = st_q.seq_adv;
  assign seg_adv_q     = st_q.seg_adv;
  assign table_flags_q = st_q.table_flags;
  assign config_q      = st_q.cfg;
  assign action_id_q   = st_q.action_id;
  assign idle_active_q = st_q.idle_active;
  assign idle_i_q      = st_q.idle_i;
  assign idle_q_q      = st_q.idle_q;
  assign idle_dac_q    = st_q.idle_dac;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !ce || stop);

  sequence s_decode_data;
    st_q.fsm == s_decode && ent.kind == kind_data;
  endsequence

  property p_fetch_six;
    st_q.fsm == s_fetch && st_q.word_cnt == 3'h0 |-> ##7 st_q.fsm == s_decode;
  endproperty
  a_fetch_six: assert property (p_fetch_six) else $error("entry fetch not six words");

  property p_data_plays;
    s_decode_data |=> st_q.fsm == s_play_req ##1 mem_req_q;
  endproperty
  a_data_plays: assert property (p_data_plays) else $error("data entry did not request segment");

  property p_idle_no_marker;
    idle_active_q |-> !marker_en_q && seg_adv_q == ADV_AUTO;
  endproperty
  a_idle_no_marker: assert property (p_idle_no_marker) else $error("idle entry carries marker");

  property p_cfg_no_flags;
    config_q |-> table_flags_q == 4'h0;
  endproperty
  a_cfg_no_flags: assert property (p_cfg_no_flags) else $error("config entry carries table flags");

  property p_req_pulse;
    mem_req_q |=> !mem_req_q;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("segment request longer than one cycle");

  property p_end_last;
    end_last_q |-> end_off_q == END_TO_LAST;
  endproperty
  a_end_last: assert property (p_end_last) else $error("end marker flag without all ones");

  property p_idle_iq;
    $rose(idle_active_q) |-> idle_i_q == st_q.words[W_IDLE_SMP][14:0]
                          && idle_q_q == st_q.words[W_IDLE_SMP][30:16];
  endproperty
  a_idle_iq: assert property (p_idle_iq) else $error("idle I or Q field wrong");

  property p_dac_fast;
    $rose(idle_active_q) && out_mode == direct_fast_output |-> idle_dac_q[13:12] == 2'b00;
  endproperty
  a_dac_fast: assert property (p_dac_fast) else $error("fast mode idle value too wide");

  property p_delay_min;
    $rose(idle_active_q) |-> st_q.dly_cnt >= MIN_DLY_INTERP;
  endproperty
  a_delay_min: assert property (p_delay_min) else $error("idle delay below minimum");

  property p_loop_back;
    st_q.fsm == s_next && st_q.cur_seq_end && st_q.seq_iter + 32'h0000_0001 < st_q.seq_count
      |=> st_q.idx == $past(st_q.seq_start);
  endproperty
  a_loop_back: assert property (p_loop_back) else $error("sequence did not loop to start");

endmodule

/* File: dv/wave_mem_model.sv */
// waveform memory stand-in: one pass finishes lag+1 cycles after each request is sampled
`timescale 1ns/1ps
module wave_mem_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // request side
  input  wire logic       mem_req_q,
  input  wire logic [3:0] lag,
  output logic            mem_done,
  output int              reqs
);
  int cnt;
  // one finish pulse per request, never unasked; a new request restarts a pending count and drops its pulse
  always @(posedge sys_clk) begin
    mem_done <= 1'b0;
    if (!rstn) begin
      cnt  <= 0;
      reqs <= 0;
    end else if (mem_req_q) begin
      cnt  <= int'(lag) + 1;
      reqs <= reqs + 1;
    end else if (cnt == 1) begin
      cnt      <= 0;
      mem_done <= 1'b1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* File: dv/test_seq_table_sequencer.sv */
// self-checking bench for the sequence table sequencer
`timescale 1ns/1ps
module test_seq_table_sequencer;
  import seq_table_pkg::*;
  logic sys_clk, rstn, wr_en, rd_en, start, mem_done, busy_q, done_q, bad_entry_q, mem_req_q, end_last_q;
  logic marker_en_q, config_q, idle_active_q;
  logic [IDX_W-1:0] wr_index, rd_index, start_index, cur_index_q;
  logic [2:0] wr_word, rd_word;
  logic [WORD_W-1:0] wr_data, rd_data_q, start_off_q, end_off_q, v;
  logic [SEG_ID_W-1:0] seg_id_q;
  logic [ADV_W-1:0] seq_adv_q, seg_adv_q;
  logic [3:0] table_flags_q, lag;
  logic [ACTION_W-1:0] action_id_q;
  logic [IQ_W-1:0] idle_i_q, idle_q_q;
  logic [FINE_DAC_W-1:0] idle_dac_q;
  out_mode_t out_mode;
  int reqs, miscompares, checked, cycles, idle_cnt, cfg_cnt, idle_run, cfg_run;
  seq_table_sequencer DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .wr_en(wr_en), .wr_index(wr_index),
    .wr_word(wr_word), .wr_data(wr_data), .rd_en(rd_en), .rd_index(rd_index), .rd_word(rd_word),
    .rd_data_q(rd_data_q), .start(start), .stop(1'b0), .start_index(start_index), .out_mode(out_mode),
    .busy_q(busy_q), .done_q(done_q), .bad_entry_q(bad_entry_q), .cur_index_q(cur_index_q),
    .mem_req_q(mem_req_q), .seg_id_q(seg_id_q), .start_off_q(start_off_q), .end_off_q(end_off_q),
    .end_last_q(end_last_q), .mem_done(mem_done), .marker_en_q(marker_en_q), .seq_adv_q(seq_adv_q),
    .seg_adv_q(seg_adv_q), .table_flags_q(table_flags_q), .config_q(config_q), .action_id_q(action_id_q),
    .idle_active_q(idle_active_q), .idle_i_q(idle_i_q), .idle_q_q(idle_q_q), .idle_dac_q(idle_dac_q));
  wave_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .mem_req_q(mem_req_q), .lag(lag), .mem_done(mem_done),
    .reqs(reqs));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ****************************************
  // monitors and access tasks
  // ****************************************
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    idle_cnt <= idle_cnt + int'(idle_active_q === 1'b1);
    cfg_cnt <= cfg_cnt + int'(config_q === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] w [6]);
    for (int k = 0; k < 6; k++) begin
      wr_en <= 1'b1; wr_index <= idx; wr_word <= 3'(k); wr_data <= w[k];
      @(posedge sys_clk);
    end
    wr_en <= 1'b0;
    // let the strobe drop for one edge before the next caller raises it
    @(posedge sys_clk);
  endtask
  task automatic get(input logic [IDX_W-1:0] idx, input logic [2:0] wd, output logic [WORD_W-1:0] d);
    rd_en <= 1'b1; rd_index <= idx; rd_word <= wd;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
    d = rd_data_q;
  endtask
  task automatic run(input string name, input logic [IDX_W-1:0] idx, input int exp_reqs);
    int n, r0, i0, c0;
    // baselines instead of clearing: the monitor owns the running counts
    n = 0;
    r0 = reqs;
    i0 = idle_cnt;
    c0 = cfg_cnt;
    start_index <= idx; start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (done_q !== 1'b1 && n < 5000);
    idle_run = idle_cnt - i0;
    cfg_run = cfg_cnt - c0;
    check(32'(reqs - r0), 32'(exp_reqs));
    check({30'h0, busy_q, done_q}, 32'h0000_0001);
    $display("test %s finished", name);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {rstn, wr_en, rd_en, start, wr_index, rd_index, start_index, wr_word, rd_word, wr_data} = '0;
    out_mode = interp_by_three; lag = 4'h0; cycles = 0; miscompares = 0; checked = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    // unused words zeroed by the writer throughout
    put(LAST_INDEX, '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hA5A5_0F0F});
    put(19'h7_FFFF, '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1});
    get(LAST_INDEX, 3'h5, v); check(v, 32'hA5A5_0F0F);
    get(19'h7_FFFF, 3'h5, v); check(v, 32'hA5A5_0F0F);
    $display("test table_access finished");
    put(19'h0, '{32'h7123_F000, 32'h1, 32'h2, 32'h3, 32'h0000_00F0, 32'hFFFF_FFFF});
    run("data_entry", 19'h0, 2);
    check(32'(seg_id_q), 32'h0000_0003);
    check(start_off_q, 32'h0000_00F0);
    check({31'h0, end_last_q}, 32'h0000_0001);
    check({31'h0, marker_en_q}, 32'h0000_0001);
    check({seq_adv_q, seg_adv_q}, 32'h0000_0023);
    check(32'(table_flags_q), 32'h0000_000F);
    // idle sample in word 3, delay in word 4, last word zero
    put(19'h1, '{32'hF000_0000, 32'h1, 32'h0, 32'h1234_5678, 32'h0000_00F0, 32'h0});
    run("idle_interp", 19'h1, 0);
    check(32'(idle_run), 32'h0000_02D0);
    check({idle_q_q, idle_i_q}, 32'h091A_5678);
    out_mode <= direct_fine_output;
    run("idle_direct", 19'h1, 0);
    check(32'(idle_run), 32'h0000_01E0);
    check(32'(idle_dac_q), 32'h0000_1678);
    out_mode <= direct_fast_output;
    run("idle_fast", 19'h1, 0);
    check(32'(idle_run), 32'h0000_0280);
    check(32'(idle_dac_q), 32'h0000_0678);
    put(19'h2, '{32'hF000_0000, 32'h1, 32'h0002_0001, 32'h7, 32'h0, 32'h0000_00EF});
    run("config_entry", 19'h2, 1);
    check({cfg_run[15:0], action_id_q}, 32'h0001_0002);
    check(end_off_q, 32'h0000_00EF);
    check(32'(seg_id_q), 32'h0000_0007);
    // unknown command code: flagged and skipped, no segment played
    put(19'h5, '{32'hF000_0000, 32'h1, 32'h0000_0002, 32'h0, 32'h0, 32'h0});
    run("bad_code", 19'h5, 0);
    check({31'h0, bad_entry_q}, 32'h0000_0001);
    lag <= 4'h5;
    put(19'h3, '{32'h1000_0000, 32'h3, 32'h1, 32'h4, 32'h0, 32'hFFFF_FFFF});
    put(19'h4, '{32'h6000_0000, 32'h9, 32'h1, 32'h5, 32'h0, 32'hFFFF_FFFF});
    run("sequence_loop", 19'h3, 6);
    check(32'(seg_id_q), 32'h0000_0005);
    check({31'h0, bad_entry_q}, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
